// File: design/hisp_pkg.sv
// Purpose: Shared constants for the two-wire haptic slave port and its master.
// Assumes: One 250 MHz core clock on both ends.
// Notes: Bus rates are given in kbit/s; the half-bit cycle counts derive from them.
package hisp_pkg;
  localparam int CLK_MHZ = 250;
  localparam int STD_RATE_KBPS = 100;
  localparam int FAST_RATE_KBPS = 400;
  // Half bit period in core cycles, rounded down (shortest allowed time)
  localparam int FAST_HALF_CYC = (CLK_MHZ * 1000) / (2 * FAST_RATE_KBPS);
  localparam int STD_HALF_CYC = (CLK_MHZ * 1000) / (2 * STD_RATE_KBPS);
  localparam logic [6:0] SLAVE_ADDR = 7'h10;
  localparam logic [6:0] GENERAL_CALL = 7'h00;
  localparam int GLITCH_CYC = 8;
  localparam int STRETCH_CYC = 16;
  // Clock hold time-out, in core cycles
  localparam int HOLD_TIMEOUT_CYC = 250000;
  localparam int BYTE_BITS = 8;
endpackage

// File: design/hisp_bus_if.sv
// Purpose: Open-drain two-wire bus joining master and slave ends.
// Assumes: Pull-ups make a released line read high.
// Notes: Enables are low while an end pulls its line low.
interface hisp_bus_if;
  logic scl_m_oe_n;
  logic sda_m_oe_n;
  logic scl_s_oe_n;
  logic sda_s_oe_n;
  logic scl;
  logic sda;
  // Wired-AND of both ends, pulled up when released
  assign scl = scl_m_oe_n & scl_s_oe_n;
  assign sda = sda_m_oe_n & sda_s_oe_n;
  modport slave (input scl, input sda, output scl_s_oe_n, output sda_s_oe_n);
  modport master (input scl, input sda, output scl_m_oe_n, output sda_m_oe_n);
endinterface

// File: design/hisp_slave.sv
// Purpose: Slave end of the two-wire port; receives bytes for the command decoder.
// Assumes: core_clk at 250 MHz, far faster than any bus edge.
// Notes: Bytes are handed out with rx_valid; rd_data feeds read transfers.
// Notes on behaviour
// - Slave only; never generates clock edges.
// - Works at 100 and 400 kbit/s.
// - Seven-bit addresses only, no ten-bit.
// - Start is data falling with clock high.
// - Data changes only while clock low.
// - Acknowledge by pulling data low after byte.
// - Not-acknowledge leaves data released high.
// - Acknowledge own address; refuse general call.
// - Ignore collision at Start; else reset.
// - Repeated Start continues with the same slave.
// - Repeated Start collision: low sample, early fall.
// - Stop is data rising with clock high.
// - Stop returns the port to idle.
// - Malformed transfers are abandoned without effect.
// - First byte after Start is address.
// - Master makes clock, arbitration, Start, Stop.
// - Own address is 0010000 binary.
// - Sample on rising, drive after falling.
// - Slave may hold clock low after byte.
// - Hold time-out releases clock, resets port.
module hisp_slave
  import hisp_pkg::*;
#(
  parameter int HOLD_TIMEOUT = HOLD_TIMEOUT_CYC,
  parameter int STRETCH = STRETCH_CYC
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  hisp_bus_if.slave bus,
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic rx_start,
  output logic rx_abort,
  output logic rx_stop,
  input wire logic [7:0] rd_data,
  output logic rd_req,
  output logic timeout_evt
);
  typedef enum {
    S_IDLE, S_ADDR, S_ACK, S_HOLD, S_WDATA, S_RDATA, S_RACK, S_IGNORE
  } hisp_state_t;

  hisp_state_t state;
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic scl_f;
  logic sda_f;
  logic scl_q;
  logic sda_q;
  logic [3:0] scl_cnt;
  logic [3:0] sda_cnt;
  logic [3:0] bit_cnt;
  logic [7:0] shreg;
  logic [7:0] txreg;
  logic read_dir;
  logic ack_bit;
  logic addressed;
  logic rs_armed;
  logic [17:0] hold_cnt;
  logic scl_oe_n;
  logic sda_oe_n;

  wire scl_rise = scl_f & ~scl_q;
  wire scl_fall = ~scl_f & scl_q;
  wire start_det = scl_f & scl_q & sda_q & ~sda_f;
  wire stop_det = scl_f & scl_q & ~sda_q & sda_f;
  // First bit slot after an ack is where a Repeated Start or Stop may legally fall
  wire mid_byte = (state == S_RDATA) || ((state == S_ADDR || state == S_WDATA) &&
    (bit_cnt != 4'h0) && !(rs_armed && bit_cnt == 4'h1));

  // Own address only; general call and ten-bit headers fall through
  function automatic logic addr_match(input logic [6:0] a);
    addr_match = (a == SLAVE_ADDR) && (a != GENERAL_CALL);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Two-flop synchronisers, then a consecutive-count deglitch
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
    end else begin
      scl_sync <= {scl_sync[0], bus.scl};
      sda_sync <= {sda_sync[0], bus.sda};
    end
  end

  // Line must hold its new level GLITCH_CYC cycles before it counts
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      scl_f <= 1'b1;
      sda_f <= 1'b1;
      scl_cnt <= 4'h0;
      sda_cnt <= 4'h0;
    end else begin
      if (scl_sync[1] == scl_f) begin
        scl_cnt <= 4'h0;
      end else if (scl_cnt == 4'(GLITCH_CYC - 1)) begin
        scl_f <= scl_sync[1];
        scl_cnt <= 4'h0;
      end else begin
        scl_cnt <= scl_cnt + 4'h1;
      end
      if (sda_sync[1] == sda_f) begin
        sda_cnt <= 4'h0;
      end else if (sda_cnt == 4'(GLITCH_CYC - 1)) begin
        sda_f <= sda_sync[1];
        sda_cnt <= 4'h0;
      end else begin
        sda_cnt <= sda_cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_f;
      sda_q <= sda_f;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Byte engine
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state <= S_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      txreg <= 8'hff;
      read_dir <= 1'b0;
      ack_bit <= 1'b1;
      addressed <= 1'b0;
      rs_armed <= 1'b0;
      hold_cnt <= 18'h0;
      scl_oe_n <= 1'b1;
      sda_oe_n <= 1'b1;
      rx_data <= 8'h00;
      rx_valid <= 1'b0;
      rx_start <= 1'b0;
      rx_abort <= 1'b0;
      rx_stop <= 1'b0;
      rd_req <= 1'b0;
      timeout_evt <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      rx_start <= 1'b0;
      rx_abort <= 1'b0;
      rx_stop <= 1'b0;
      rd_req <= 1'b0;
      timeout_evt <= 1'b0;
      if (stop_det) begin
        state <= S_IDLE;
        sda_oe_n <= 1'b1;
        scl_oe_n <= 1'b1;
        addressed <= 1'b0;
        bit_cnt <= 4'h0;
        rs_armed <= 1'b0;
        rx_stop <= addressed;
        rx_abort <= addressed && mid_byte;
      end else if (start_det) begin
        // Repeated Start keeps the session; mid-byte Start aborts it
        state <= S_ADDR;
        bit_cnt <= 4'h0;
        sda_oe_n <= 1'b1;
        rs_armed <= 1'b0;
        rx_start <= 1'b1;
        rx_abort <= addressed && mid_byte;
      end else if (!sda_oe_n && scl_rise && sda_f) begin
        state <= S_IDLE;
        sda_oe_n <= 1'b1;
        addressed <= 1'b0;
        rx_abort <= 1'b1;
      end else begin
        case (state)
          S_IDLE: begin
            sda_oe_n <= 1'b1;
          end
          S_ADDR, S_WDATA: begin
            if (scl_rise) begin
              shreg <= {shreg[6:0], sda_f};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == 4'(BYTE_BITS)) begin
              bit_cnt <= 4'h0;
              if (state == S_ADDR) begin
                ack_bit <= ~addr_match(shreg[7:1]);
                read_dir <= shreg[0];
                addressed <= addr_match(shreg[7:1]);
                sda_oe_n <= ~addr_match(shreg[7:1]);
                state <= addr_match(shreg[7:1]) ? S_ACK : S_IGNORE;
                rd_req <= addr_match(shreg[7:1]) & shreg[0];
              end else begin
                rx_data <= shreg;
                rx_valid <= 1'b1;
                ack_bit <= 1'b0;
                sda_oe_n <= 1'b0;
                state <= S_ACK;
              end
            end
          end
          S_ACK: begin
            if (scl_fall) begin
              // Brief hold so the decoder can take the byte
              sda_oe_n <= 1'b1;
              scl_oe_n <= 1'b0;
              hold_cnt <= 18'h0;
              state <= S_HOLD;
            end
          end
          S_HOLD: begin
            hold_cnt <= hold_cnt + 18'h1;
            if (hold_cnt == 18'(HOLD_TIMEOUT)) begin
              scl_oe_n <= 1'b1;
              state <= S_IDLE;
              addressed <= 1'b0;
              timeout_evt <= 1'b1;
            end else if (hold_cnt == 18'(STRETCH)) begin
              scl_oe_n <= 1'b1;
              rs_armed <= ~read_dir;
              if (read_dir) begin
                txreg <= {rd_data[6:0], 1'b1};
                sda_oe_n <= rd_data[7];
                bit_cnt <= 4'h1;
                state <= S_RDATA;
              end else begin
                state <= S_WDATA;
              end
            end
          end
          S_RDATA: begin
            if (scl_fall) begin
              if (bit_cnt == 4'(BYTE_BITS)) begin
                sda_oe_n <= 1'b1;
                state <= S_RACK;
              end else begin
                sda_oe_n <= txreg[7];
                txreg <= {txreg[6:0], 1'b1};
                bit_cnt <= bit_cnt + 4'h1;
              end
            end
          end
          S_RACK: begin
            if (scl_rise) begin
              if (sda_f) begin
                state <= S_IGNORE;
              end else begin
                rd_req <= 1'b1;
                ack_bit <= 1'b0;
                state <= S_ACK;
              end
            end
          end
          S_IGNORE: begin
            sda_oe_n <= 1'b1;
          end
          default: begin
            state <= S_IDLE;
          end
        endcase
        if (rs_armed && scl_fall) begin
          rs_armed <= 1'b0;
        end
      end
    end
  end

  // Clock is only ever held low, never toggled
  assign bus.scl_s_oe_n = scl_oe_n;
  assign bus.sda_s_oe_n = sda_oe_n;
endmodule

// File: design/hisp_master.sv
// Purpose: Bus master end that issues Start, bytes and Stop on command.
// Assumes: Same core clock as the slave; lines pass through two flops.
// Notes: Waits while the slave holds the clock low.
module hisp_master
  import hisp_pkg::*;
#(
  parameter int HALF_CYC = FAST_HALF_CYC
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  hisp_bus_if.master bus,
  input wire logic cmd_valid,
  input wire logic cmd_start,
  input wire logic cmd_stop,
  input wire logic cmd_read,
  input wire logic [7:0] cmd_data,
  output logic cmd_ready,
  output logic [7:0] rsp_data,
  output logic rsp_ack,
  output logic rsp_valid
);
  typedef enum {M_IDLE, M_START, M_BITLO, M_BITHI, M_STOP1, M_STOP2} hisp_mstate_t;

  hisp_mstate_t state;
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic [15:0] tmr;
  logic [3:0] bit_cnt;
  logic [8:0] sh;
  logic [8:0] rx;
  logic rd;
  logic stop_pend;
  logic scl_oe_n;
  logic sda_oe_n;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
    end else begin
      scl_sync <= {scl_sync[0], bus.scl};
      sda_sync <= {sda_sync[0], bus.sda};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Half-period sequencer; data bits change only with clock low, Start and Stop with clock high
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state <= M_IDLE;
      tmr <= 16'h0;
      bit_cnt <= 4'h0;
      sh <= 9'h1ff;
      rx <= 9'h0;
      rd <= 1'b0;
      stop_pend <= 1'b0;
      scl_oe_n <= 1'b1;
      sda_oe_n <= 1'b1;
      cmd_ready <= 1'b0;
      rsp_data <= 8'h00;
      rsp_ack <= 1'b0;
      rsp_valid <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      cmd_ready <= 1'b0;
      tmr <= tmr + 16'h1;
      case (state)
        M_IDLE: begin
          tmr <= 16'h0;
          if (cmd_valid && !cmd_ready) begin
            cmd_ready <= 1'b1;
            rd <= cmd_read;
            stop_pend <= cmd_stop;
            // Read releases data; the ninth bit acks unless a Stop follows, then it is released
            sh <= cmd_read ? {8'hff, cmd_stop} : {cmd_data, 1'b1};
            bit_cnt <= 4'h0;
            if (cmd_start) begin
              // Clock stays as it is; a slave may still hold it after an ack
              sda_oe_n <= 1'b1;
              state <= M_START;
            end else begin
              state <= M_BITLO;
            end
          end
        end
        M_START: begin
          if (tmr == 16'(HALF_CYC)) begin
            scl_oe_n <= 1'b1;
            if (!scl_sync[1]) begin
              tmr <= tmr;
            end else if (!sda_sync[1]) begin
              // Data low as the clock rose: line lost, give up
              rsp_ack <= 1'b0;
              rsp_valid <= 1'b1;
              state <= M_IDLE;
            end
          end else if (tmr == 16'(2 * HALF_CYC)) begin
            sda_oe_n <= 1'b0;
          end else if (tmr == 16'(3 * HALF_CYC)) begin
            scl_oe_n <= 1'b0;
            tmr <= 16'h0;
            state <= M_BITLO;
          end else if (tmr > 16'(HALF_CYC) && tmr < 16'(2 * HALF_CYC) && !scl_sync[1]) begin
            // Clock fell before our data went low
            rsp_ack <= 1'b0;
            rsp_valid <= 1'b1;
            state <= M_IDLE;
          end
        end
        M_BITLO: begin
          if (tmr == 16'(HALF_CYC / 2)) begin
            sda_oe_n <= sh[8];
          end else if (tmr >= 16'(HALF_CYC)) begin
            scl_oe_n <= 1'b1;
            // Stretch: stay in the low phase until the line is seen high
            if (scl_sync[1]) begin
              tmr <= 16'h0;
              state <= M_BITHI;
            end
          end
        end
        M_BITHI: begin
          if (tmr == 16'(HALF_CYC)) begin
            rx <= {rx[7:0], sda_sync[1]};
            scl_oe_n <= 1'b0;
            tmr <= 16'h0;
            sh <= {sh[7:0], 1'b1};
            if (bit_cnt == 4'(BYTE_BITS)) begin
              rsp_data <= rx[7:0];
              rsp_ack <= ~sda_sync[1];
              rsp_valid <= 1'b1;
              state <= stop_pend ? M_STOP1 : M_IDLE;
            end else begin
              bit_cnt <= bit_cnt + 4'h1;
              state <= M_BITLO;
            end
          end
        end
        M_STOP1: begin
          if (tmr == 16'(HALF_CYC / 2)) begin
            sda_oe_n <= 1'b0;
          end else if (tmr >= 16'(HALF_CYC)) begin
            scl_oe_n <= 1'b1;
            // A held clock delays the Stop
            if (scl_sync[1]) begin
              tmr <= 16'h0;
              state <= M_STOP2;
            end
          end
        end
        M_STOP2: begin
          if (tmr == 16'(HALF_CYC)) begin
            sda_oe_n <= 1'b1;
            tmr <= 16'h0;
            state <= M_IDLE;
          end
        end
        default: begin
          state <= M_IDLE;
        end
      endcase
    end
  end

  assign bus.scl_m_oe_n = scl_oe_n;
  assign bus.sda_m_oe_n = sda_oe_n;
endmodule

// File: verification/hisp_assertions.sv
// Purpose: Concurrent checks on the two-wire bus between master and slave ends.
// Assumes: One core clock; bit time well above the slave's input latency.
// Notes: Sees only interface signals; HOLD_TIMEOUT must match the slave's.
module hisp_assertions #(
  parameter int HOLD_TIMEOUT = 2000
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic scl_m_oe_n,
  input wire logic sda_m_oe_n,
  input wire logic scl_s_oe_n,
  input wire logic sda_s_oe_n,
  input wire logic scl,
  input wire logic sda
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////
  // Cycles the slave has held the clock low
  int hold_cnt;
  always_ff @(posedge core_clk) begin
    if (sys_rst || scl_s_oe_n) begin
      hold_cnt <= 0;
    end else begin
      hold_cnt <= hold_cnt + 1;
    end
  end
  ////////////////////////////////////////
  sequence s_start;
    scl && $fell(sda);
  endsequence
  sequence s_stop;
    scl && $rose(sda);
  endsequence
  // Slave data low level kept for eight cycles, then let go within 1000 more
  sequence s_drive_low;
    (!sda_s_oe_n) [*8] ##[1:1000] sda_s_oe_n;
  endsequence
  sequence s_stretch;
    (!scl_s_oe_n) [*8] ##[1:20] scl_s_oe_n;
  endsequence
  ////////////////////////////////////////
  a_sda_change_low: assert property ($changed(sda_s_oe_n) |-> !scl)
    else $error("slave data changed while clock high");
  a_hold_no_edge: assert property ($fell(scl_s_oe_n) |-> !$past(scl))
    else $error("slave pulled clock low from high");
  a_hold_length: assert property ($fell(scl_s_oe_n) |-> s_stretch)
    else $error("clock hold of wrong length");
  a_hold_timeout: assert property (hold_cnt <= HOLD_TIMEOUT + 4)
    else $error("clock hold outlived its time-out");
  a_ack_hold: assert property ($fell(sda_s_oe_n) |-> s_drive_low)
    else $error("slave low level not held or never released");
  a_sync_latency: assert property ($fell(scl) |=> $stable(sda_s_oe_n) [*8])
    else $error("slave reacted before input filtering");
  a_stop_idle: assert property (s_stop |-> (sda_s_oe_n && scl_s_oe_n) [*8])
    else $error("slave drove a line after stop");
  a_start_shape: assert property (s_start |=> scl [*8])
    else $error("clock not held high after start");
  a_master_half: assert property ($rose(scl_m_oe_n) |-> scl_m_oe_n [*8])
    else $error("master clock high phase too short");
endmodule

// File: verification/haptic_i2c_slave_port_tb.sv
// Purpose: Self-checking bench for the slave port against the master end.
// Assumes: Short bit time and hold time-out keep the run brief.
// Notes: A second bus is bit-banged by the bench to break framing.
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin err_total++; \
  $display("[ERR] %s expected %0h seen %0h", nm, e, g); end end
module haptic_i2c_slave_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import hisp_pkg::*;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic cmd_valid, cmd_start, cmd_stop, cmd_read, cmd_ready, rsp_ack, rsp_valid;
  logic [7:0] cmd_data, rsp_data, rd_data, rx_data, d, a;
  logic rx_valid, rx_start, rx_abort, rx_stop, rd_req, b_valid, b_abort, b_stop, ack;
  logic tmo_evt;
  logic bb_scl = 1'b1;
  logic bb_sda = 1'b1;
  int err_total, tests_run, n_ready, n_rsp, n_start, n_stop, n_abort, n_rdreq;
  int b_nval, b_nabort, b_nstop, i, starts, stops, n_tmo;
  integer seed;
  logic [7:0] exp_q[$];
  always #2 core_clk = ~core_clk;
  ////////////////////////////////////////
  hisp_bus_if bus_a();
  hisp_bus_if bus_b();
  assign bus_b.scl_m_oe_n = bb_scl;
  assign bus_b.sda_m_oe_n = bb_sda;
  hisp_slave #(.HOLD_TIMEOUT(2000)) u_hisp_slave (.core_clk(core_clk),
    .sys_rst(sys_rst), .bus(bus_a), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_start(rx_start), .rx_abort(rx_abort), .rx_stop(rx_stop), .rd_data(rd_data),
    .rd_req(rd_req), .timeout_evt(tmo_evt));
  hisp_slave #(.HOLD_TIMEOUT(2000)) u_hisp_slave_b (.core_clk(core_clk),
    .sys_rst(sys_rst), .bus(bus_b), .rx_data(), .rx_valid(b_valid), .rx_start(),
    .rx_abort(b_abort), .rx_stop(b_stop), .rd_data(rd_data), .rd_req(), .timeout_evt());
  hisp_master #(.HALF_CYC(40)) u_hisp_master (.core_clk(core_clk), .sys_rst(sys_rst),
    .bus(bus_a), .cmd_valid(cmd_valid), .cmd_start(cmd_start), .cmd_stop(cmd_stop),
    .cmd_read(cmd_read), .cmd_data(cmd_data), .cmd_ready(cmd_ready), .rsp_data(rsp_data),
    .rsp_ack(rsp_ack), .rsp_valid(rsp_valid));
  hisp_assertions #(.HOLD_TIMEOUT(2000)) u_hisp_assertions (.core_clk(core_clk),
    .sys_rst(sys_rst), .scl_m_oe_n(bus_a.scl_m_oe_n), .sda_m_oe_n(bus_a.sda_m_oe_n),
    .scl_s_oe_n(bus_a.scl_s_oe_n), .sda_s_oe_n(bus_a.sda_s_oe_n), .scl(bus_a.scl),
    .sda(bus_a.sda));
  ////////////////////////////////////////
  // Pulse counts and the byte model, sampled at every rising edge
  always @(posedge core_clk) begin
    if (!sys_rst) begin
      n_ready += cmd_ready;
      n_rsp += rsp_valid;
      n_start += rx_start;
      n_stop += rx_stop;
      n_abort += rx_abort;
      n_rdreq += rd_req;
      b_nval += b_valid;
      b_nabort += b_abort;
      b_nstop += b_stop;
      n_tmo += tmo_evt;
      if (rx_valid) begin
        `CHK("rx_data", exp_q[0], rx_data)
        if (exp_q.size() > 0) void'(exp_q.pop_front());
      end
    end
  end
  ////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic wait_cnt(ref int c, input int v);
    for (int n = 0; c < v && n < 4000; n++) begin
      @(posedge core_clk);
      #1;
    end
    if (c < v) begin
      err_total++;
      $display("[ERR] wait expected %0d seen %0d", v, c);
      summarize();
    end
  endtask
  task automatic cmd(input logic st, input logic sp, input logic rd, input logic [7:0] v);
    cmd_start = st;
    cmd_stop = sp;
    cmd_read = rd;
    cmd_data = v;
    cmd_valid = 1'b1;
    wait_cnt(n_ready, n_ready + 1);
    cmd_valid = 1'b0;
    wait_cnt(n_rsp, n_rsp + 1);
  endtask
  // Bit-banged second bus; clock first, data once the filter has settled
  task automatic bb(input logic c, input logic v);
    int n;
    bb_scl = c;
    repeat (12) @(posedge core_clk);
    #1;
    bb_sda = v;
    for (n = 0; c && bus_b.scl !== 1'b1 && n < 200; n++) @(posedge core_clk);
    if (c && bus_b.scl !== 1'b1) begin
      err_total++;
      $display("[ERR] bus_b_scl expected 1 seen %0b", bus_b.scl);
      summarize();
    end
    repeat (40) @(posedge core_clk);
    #1;
  endtask
  task automatic send(input logic [7:0] v, output logic k);
    for (int j = 7; j >= 0; j--) begin
      bb(1'b0, v[j]);
      bb(1'b1, v[j]);
    end
    bb(1'b0, 1'b1);
    bb(1'b1, 1'b1);
    k = bus_b.sda;
    bb(1'b0, 1'b1);
  endtask
  ////////////////////////////////////////
  initial begin
    seed = 32'ha64c67ae;
    {cmd_valid, cmd_start, cmd_stop, cmd_read} = 4'h0;
    cmd_data = 8'h00;
    rd_data = 8'h00;
    repeat (2) @(posedge core_clk);
    #1 sys_rst = 1'b0;
    // Write of two random bytes, then stop
    cmd(1'b1, 1'b0, 1'b0, 8'h20);
    `CHK("addr_ack", 1'b1, rsp_ack)
    for (i = 0; i < 2; i++) begin
      d = 8'($random(seed));
      exp_q.push_back(d);
      cmd(1'b0, i == 1, 1'b0, d);
      `CHK("data_ack", 1'b1, rsp_ack)
    end
    wait_cnt(n_stop, 1);
    `CHK("stop_count", 1, n_stop)
    // Address sweep: general call, own, ten-bit header, random others
    stops = 1;
    for (i = 0; i < 5; i++) begin
      a = (i == 0) ? 8'h00 : (i == 1) ? 8'h20 : (i == 2) ? 8'hf0 : 8'($random(seed));
      if (i > 2 && a[7:1] == SLAVE_ADDR) a = a ^ 8'h02;
      cmd(1'b1, 1'b1, 1'b0, a);
      `CHK("addr_ack", a[7:1] == SLAVE_ADDR && !a[0], rsp_ack)
      if (a[7:1] == SLAVE_ADDR) stops++;
    end
    wait_cnt(n_stop, stops);
    `CHK("stop_count", stops, n_stop)
    // Write, repeated start, single read ended by not-acknowledge
    rd_data = 8'($random(seed));
    cmd(1'b1, 1'b0, 1'b0, 8'h20);
    d = 8'($random(seed));
    exp_q.push_back(d);
    cmd(1'b0, 1'b0, 1'b0, d);
    cmd(1'b1, 1'b0, 1'b0, 8'h21);
    `CHK("rstart_ack", 1'b1, rsp_ack)
    cmd(1'b0, 1'b1, 1'b1, 8'h00);
    `CHK("rd_byte", rd_data, rsp_data)
    wait_cnt(n_stop, stops + 1);
    `CHK("rd_req", 1, n_rdreq)
    starts = 8;
    `CHK("start_count", starts, n_start)
    `CHK("abort_count", 0, n_abort)
    `CHK("bytes_left", 0, exp_q.size())
    // Second bus: own address, mid-byte start, general call, stop
    bb(1'b1, 1'b1);
    bb(1'b1, 1'b0);
    send(8'h20, ack);
    `CHK("wire_ack", 1'b0, ack)
    for (i = 0; i < 3; i++) begin
      bb(1'b0, i[0]);
      bb(1'b1, i[0]);
    end
    bb(1'b0, 1'b1);
    bb(1'b1, 1'b1);
    bb(1'b1, 1'b0);
    `CHK("mid_abort", 1, b_nabort)
    send(8'h00, ack);
    `CHK("wire_nack", 1'b1, ack)
    bb(1'b0, 1'b0);
    bb(1'b1, 1'b0);
    bb(1'b1, 1'b1);
    `CHK("b_bytes", 0, b_nval)
    `CHK("b_stop", 0, b_nstop)
    `CHK("timeout_count", 0, n_tmo)
    summarize();
  end
endmodule
